// File: src/ppwm_pkg.sv
// Package for the prescaled modulation output block
// Assumes a single 20 MHz clock domain and a plain register port
package ppwm_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_COMPARE = 8'h8E;
    localparam logic [7:0] ADDR_PRESCALE = 8'h8F;
    localparam logic [7:0] ADDR_ENABLE = 8'hFE;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hF0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hF1;
    localparam logic [7:0] ADDR_COUNT = 8'hF2;

    // Field positions
    localparam int ENABLE_BIT = 0;
    localparam int IRQ_OVF_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    // Counter limits
    localparam logic [7:0] CNT_TOP = 8'hFE;
    localparam logic [7:0] CMP_ALWAYS_LOW = 8'hFF;

    // Core clock steps once per two oscillator periods
    localparam logic DIV2_RST = 1'b0;

endpackage : ppwm_pkg

// File: src/ppwm_top.sv
// Prescaled single channel pulse width modulation output
// Assumes one clock, synchronous reset and a one-cycle register port
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps

module ppwm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Low power state
    input wire logic idle_mode,
    input wire logic power_down,
    // Shared pin
    input wire logic shared_output_pin_in,
    output logic shared_output_pin_out,
    output logic shared_output_pin_oe,
    // General port bit latch
    input wire logic port_latch,
    output logic port_pin_value,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] compare;
        logic [7:0] prescale;
        logic [7:0] enable;
        logic [7:0] mask;
        logic irq_stat;
        logic div2;
        logic [7:0] pre_cnt;
        logic [7:0] count;
        logic pwm_out;
        logic [7:0] rdata;
        logic [2:0] pin_sync;
        logic pin_val;
    } ppwm_state_t;

    ppwm_state_t st_r;
    ppwm_state_t st_nxt;

    logic tick;
    logic step;
    logic wrap;
    logic pwm_eff;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        // Oscillator divide-by-two, then private prescaler
        tick = st_r.div2 && (st_r.pre_cnt == st_r.prescale);
        step = tick && !idle_mode && !power_down;
        wrap = step && (st_r.count == ppwm_pkg::CNT_TOP);
        if (!idle_mode && !power_down) begin
            st_nxt.div2 = !st_r.div2;
            if (st_r.div2) begin
                st_nxt.pre_cnt = tick ? 8'h00 : st_r.pre_cnt + 8'h01;
            end
        end
        if (step) begin
            st_nxt.count = wrap ? 8'h00 : st_r.count + 8'h01;
            // Zero wins over match so compare 255 never sets, 0 always sets
            if (wrap) begin
                st_nxt.pwm_out = (st_r.compare == 8'h00);
            end else if (st_r.count + 8'h01 == st_r.compare) begin
                st_nxt.pwm_out = 1'b1;
            end
        end
        // Pin input sampler
        st_nxt.pin_sync = {st_r.pin_sync[1:0], shared_output_pin_in};
        if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
            st_nxt.pin_val = st_r.pin_sync[2];
        end
        // Register writes
        if (reg_wr) begin
            if (reg_addr == ppwm_pkg::ADDR_COMPARE) begin
                st_nxt.compare = reg_wdata;
            end else if (reg_addr == ppwm_pkg::ADDR_PRESCALE) begin
                st_nxt.prescale = reg_wdata;
            end else if (reg_addr == ppwm_pkg::ADDR_ENABLE) begin
                st_nxt.enable = reg_wdata;
            end else if (reg_addr == ppwm_pkg::ADDR_IRQ_MASK) begin
                st_nxt.mask = reg_wdata;
            end else if (reg_addr == ppwm_pkg::ADDR_IRQ_STATUS) begin
                if (reg_wdata[ppwm_pkg::IRQ_OVF_BIT]) begin
                    st_nxt.irq_stat = 1'b0;
                end
            end
        end
        // Set wins over clear
        if (wrap) begin
            st_nxt.irq_stat = 1'b1;
        end
        // Register reads
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == ppwm_pkg::ADDR_COMPARE) begin
                st_nxt.rdata = st_r.compare;
            end else if (reg_addr == ppwm_pkg::ADDR_PRESCALE) begin
                st_nxt.rdata = st_r.prescale;
            end else if (reg_addr == ppwm_pkg::ADDR_ENABLE) begin
                st_nxt.rdata = st_r.enable;
            end else if (reg_addr == ppwm_pkg::ADDR_IRQ_MASK) begin
                st_nxt.rdata = st_r.mask;
            end else if (reg_addr == ppwm_pkg::ADDR_IRQ_STATUS) begin
                st_nxt.rdata = {7'h00, st_r.irq_stat};
            end else if (reg_addr == ppwm_pkg::ADDR_COUNT) begin
                st_nxt.rdata = st_r.count;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.compare <= ppwm_pkg::RST_COMPARE;
            st_r.prescale <= ppwm_pkg::RST_PRESCALE;
            st_r.enable <= ppwm_pkg::RST_ENABLE;
            st_r.mask <= ppwm_pkg::RST_MASK;
            st_r.div2 <= ppwm_pkg::DIV2_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pwm_eff = st_r.pwm_out || idle_mode || power_down;
    always_comb begin
        if (st_r.enable[ppwm_pkg::ENABLE_BIT]) begin
            shared_output_pin_out = pwm_eff;
            shared_output_pin_oe = 1'b1;
        end else begin
            // Quasi-bidirectional port: drive low only, pull-up outside
            shared_output_pin_out = 1'b0;
            shared_output_pin_oe = !port_latch;
        end
    end
    assign port_pin_value = st_r.pin_val;
    assign reg_rdata = st_r.rdata;
    assign irq = st_r.irq_stat && st_r.mask[ppwm_pkg::IRQ_OVF_BIT];

endmodule : ppwm_top

// File: verif/ppwm_monitor.sv
// Port checker for the modulation block
// Assumes the register strobes and low power levels seen at the top ports
`timescale 1ns/1ps
module ppwm_monitor (
    // Inputs of the block
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic idle_mode,
    input wire logic power_down,
    input wire logic port_latch,
    // Outputs of the block
    input wire logic [7:0] reg_rdata,
    input wire logic shared_output_pin_out,
    input wire logic shared_output_pin_oe,
    input wire logic irq
);
    logic en_r;
    logic msk_r;
    logic [7:0] cmp_r;
    always_ff @(posedge clk) begin
        if (rst) {en_r, msk_r, cmp_r} <= 10'h000;
        else if (reg_wr && clk_en) begin
            if (reg_addr == 8'hFE) en_r <= reg_wdata[0];
            if (reg_addr == 8'hF1) msk_r <= reg_wdata[0];
            if (reg_addr == 8'h8E) cmp_r <= reg_wdata;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmp_read;
        reg_rd && clk_en && reg_addr == 8'h8E;
    endsequence
    a_cmp_read: assert property (s_cmp_read |=> reg_rdata == $past(cmp_r))
        else $error("compare read");
    a_rst_off: assert property (disable iff (1'b0) rst && $past(rst) |->
        !irq && shared_output_pin_oe == !port_latch) else $error("reset state");
    a_drive_on: assert property (en_r |-> shared_output_pin_oe)
        else $error("pin not driven");
    a_port_mode: assert property (!en_r |-> shared_output_pin_oe == !port_latch)
        else $error("port drive");
    a_sleep_high: assert property (en_r && (idle_mode || power_down) |-> shared_output_pin_out)
        else $error("sleep level");
    a_irq_masked: assert property (!msk_r |-> !irq)
        else $error("masked irq");
    a_wrap_low: assert property ($rose(irq) && $past(msk_r) && en_r && cmp_r != 8'h00 &&
        $past(cmp_r) != 8'h00 && !idle_mode && !power_down |-> !shared_output_pin_out)
        else $error("wrap level");
    a_idle_frozen: assert property (idle_mode && $past(idle_mode) && $past(msk_r) |->
        !$rose(irq)) else $error("idle wrap");
endmodule : ppwm_monitor
bind ppwm_top ppwm_monitor u_mon (.*);

// File: verif/ppwm_pin_model.sv
// External load on the shared pin: pull-up and a switch to ground
// Assumes pin drive and enable from the block
`timescale 1ns/1ps
module ppwm_pin_model (
    // Block side
    input wire logic drv_out,
    input wire logic drv_oe,
    // Bench side
    input wire logic ext_low,
    output logic pin_level
);
    assign pin_level = drv_oe ? drv_out : !ext_low;
endmodule : ppwm_pin_model

// File: verif/ppwm_top_bench.sv
// Bench for the modulation block: register calls and pin checks
// Assumes the pin model resolves the shared pin
`timescale 1ns/1ps
module ppwm_top_bench;
    localparam int P = 1;
    localparam int C = 128;
    logic clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, idle_mode = 0;
    logic power_down = 0, port_latch = 1, ext_low = 0, shared_output_pin_in;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv, q;
    logic shared_output_pin_out, shared_output_pin_oe, port_pin_value, irq;
    int errors = 0, checks_done = 0, cyc = 0, hi, lo;
    always #25 clk = !clk;
    ppwm_top DUT (.*);
    ppwm_pin_model u_pin (.drv_out(shared_output_pin_out), .drv_oe(shared_output_pin_oe),
        .ext_low(ext_low), .pin_level(shared_output_pin_in));
    ////////////////////////////////////////
    task chk(logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask : chk
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 0;
        #1;
    endtask : wr
    task rd(logic [7:0] a);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 0;
        #1 rv = reg_rdata;
    endtask : rd
    task run(int n);
        repeat (n) @(posedge clk) #1;
    endtask : run
    task give_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict;
        end
    end
    initial begin
        run(3);
        rst <= 0;
        rd(8'hFE);
        chk(rv, 0);
        ext_low <= 1;
        run(8);
        chk({shared_output_pin_oe, port_pin_value}, 0);
        rd(8'h10);
        chk(rv, 0);
        wr(8'h8F, P);
        wr(8'h8E, C);
        wr(8'hF1, 1);
        wr(8'hFE, 1);
        rd(8'h8E);
        chk(rv, C);
        @(posedge shared_output_pin_out);
        for (hi = 0; shared_output_pin_out === 1'b1; hi++) run(1);
        for (lo = 0; shared_output_pin_out === 1'b0; lo++) run(1);
        chk(hi, 2 * (1 + P) * (255 - C));
        chk(hi + lo, 2 * (1 + P) * 255);
        chk(irq, 1);
        wr(8'hF0, 1);
        chk(irq, 0);
        for (int i = 0; i < 2; i++) begin
            wr(8'h8E, i ? 8'hFF : 8'h00);
            run(2100);
            repeat (4) begin
                chk(shared_output_pin_out, !i);
                run(300);
            end
        end
        idle_mode <= 1;
        rd(8'hF2);
        q = rv;
        run(40);
        rd(8'hF2);
        chk({shared_output_pin_out, rv}, {1'b1, q});
        {idle_mode, power_down} <= 2'b01;
        run(2);
        chk(shared_output_pin_out, 1);
        power_down <= 0;
        wr(8'hFE, 0);
        wr(8'hF0, 1);
        port_latch <= 0;
        run(1100);
        chk({irq, shared_output_pin_oe, shared_output_pin_out}, 3'b110);
        give_verdict;
    end
endmodule : ppwm_top_bench
